// ---- inc/smbus_defs.vh ----
// Purpose: shared constants of the two-wire serial interface
// Assumes: included by bare name from the design files
// Notes:   definitions only, no logic
`ifndef SMBUS_DEFS_VH
`define SMBUS_DEFS_VH

// ************************************************************
// clock and bit timing
// ************************************************************
`define SMB_SYSCLK_HZ   40000000
`define SMB_RATE_DIV    20
`define SMB_HALF_CYC    (`SMB_RATE_DIV / 2)
`define SMB_TMR_W       16
`define SMB_TMR_ZERO    16'h0000
`define SMB_EXT_W       8

// ************************************************************
// byte layout
// ************************************************************
`define SMB_ADDR_W      7
`define SMB_BIT_CNT_W   3
`define SMB_BIT_FIRST   3'h0
`define SMB_BIT_LAST    3'h7
`define SMB_BYTE_ZERO   8'h00

// ************************************************************
// one-hot engine states
// ************************************************************
`define SMB_ST_W        6
`define SMB_ST_IDLE     6'h01
`define SMB_ST_MSTART   6'h02
`define SMB_ST_BITS     6'h04
`define SMB_ST_ACKB     6'h08
`define SMB_ST_HOLD     6'h10
`define SMB_ST_MSTOP    6'h20

// ************************************************************
// sub-phases of start and stop generation
// ************************************************************
`define SMB_PH_W        3
`define SMB_PH_0        3'h0
`define SMB_PH_1        3'h1
`define SMB_PH_2        3'h2
`define SMB_PH_3        3'h3
`define SMB_PH_4        3'h4

`endif

// ---- verilog/smb_phase_timer.v ----
// Purpose: down counter timing scl phases and start/stop setup
// Assumes: load_i is a one-cycle pulse from the engine
// Notes:   done_o is high while the count stands at zero
`timescale 1ns/1ps
`include "smbus_defs.vh"

module smb_phase_timer #(
  parameter W = `SMB_TMR_W
) (
  input  wire         clk_i,
  input  wire         rstn_i,
  input  wire         load_i,
  input  wire [W-1:0] value_i,
  output wire         done_o
);

  reg [W-1:0] cnt_r;

  // load or count down to zero
  always @(posedge clk_i)
  begin
    if (!rstn_i)
      cnt_r <= {W{1'h0}};
    else if (load_i)
      cnt_r <= value_i;
    else if (cnt_r != {W{1'h0}})
      cnt_r <= cnt_r - {{(W-1){1'h0}}, 1'h1};
  end

  assign done_o = (cnt_r == {W{1'h0}});

endmodule // smb_phase_timer

// ---- verilog/smbus_master_slave_interface.v ----
// Purpose: two-wire master/slave serial interface with arbitration
// Assumes: scl/sda open drain; pins arrive asynchronous to clk_i
// Notes:   software talks through plain control and status ports
`timescale 1ns/1ps
`include "smbus_defs.vh"

module smbus_master_slave_interface #(
  parameter HALF_CYC = `SMB_HALF_CYC
) (
  input  wire                   clk_i,
  input  wire                   rstn_i,
  input  wire                   enable_i,
  input  wire                   hardware_ack_enable_i,
  input  wire [`SMB_ADDR_W-1:0] slave_addr_i,
  input  wire                   start_req_i,
  input  wire                   stop_req_i,
  input  wire                   ack_we_i,
  input  wire                   ack_i,
  input  wire                   data_we_i,
  input  wire [7:0]             data_i,
  input  wire                   flag_clr_i,
  input  wire [`SMB_EXT_W-1:0]  low_ext_i,
  input  wire                   scl_i,
  input  wire                   sda_i,
  output reg                    scl_o,
  output wire                   scl_oe_o,
  output reg                    sda_o,
  output wire                   sda_oe_o,
  output wire [7:0]             serial_byte_buffer_o,
  output wire [3:0]             status_vector_o,
  output wire                   ack_request_flag_o,
  output wire                   arbitration_lost_flag_o,
  output wire                   ack_o,
  output wire                   int_flag_o,
  output wire                   bus_busy_o
);

  localparam [`SMB_TMR_W-1:0] HALF_W = HALF_CYC[`SMB_TMR_W-1:0];

  // ************************************************************
  // state and flags
  // ************************************************************
  reg [`SMB_ST_W-1:0]     state_r;
  reg [`SMB_PH_W-1:0]     phase_r;
  reg [`SMB_BIT_CNT_W-1:0] bit_cnt_r;
  reg [7:0]               buf_r;
  reg [7:0]               rx_sh_r;
  reg [7:0]               tx_sh_r;
  reg                     scl_oe_r;
  reg                     sda_oe_r;
  reg                     master_r;
  reg                     tx_r;
  reg                     sta_r;
  reg                     sto_r;
  reg                     ack_request_flag_r;
  reg                     arbl_r;
  reg                     ack_r;
  reg                     si_r;
  reg                     busy_r;
  reg                     addr_ph_r;
  reg                     rw_r;
  reg                     rep_r;
  reg                     skip_fall_r;
  reg                     tmr_load_r;
  reg [`SMB_TMR_W-1:0]    tmr_val_r;
  reg                     scl_m_r;
  reg                     scl_s_r;
  reg                     scl_d_r;
  reg                     sda_m_r;
  reg                     sda_s_r;
  reg                     sda_d_r;
  wire                    tmr_zero;
  wire                    tmr_done;
  wire                    scl_rise;
  wire                    scl_fall;
  wire                    start_det;
  wire                    stop_det;
  wire [`SMB_TMR_W-1:0]   low_val;

  // ************************************************************
  // pin synchronisers and bus condition detection
  // ************************************************************

  // two flops per pin, third flop for edges
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      scl_m_r <= 1'h1;
      scl_s_r <= 1'h1;
      scl_d_r <= 1'h1;
      sda_m_r <= 1'h1;
      sda_s_r <= 1'h1;
      sda_d_r <= 1'h1;
    end
    else
    begin
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // edges and start/stop seen on the wire
  assign scl_rise  = scl_s_r & ~scl_d_r;
  assign scl_fall  = ~scl_s_r & scl_d_r;
  assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_det  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // low phase stretched by software count
  assign low_val  = HALF_W + {{(`SMB_TMR_W-`SMB_EXT_W){1'h0}}, low_ext_i};
  assign tmr_done = tmr_zero & ~tmr_load_r;

  smb_phase_timer #(
    .W       (`SMB_TMR_W)
  ) u_timer (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .load_i  (tmr_load_r),
    .value_i (tmr_val_r),
    .done_o  (tmr_zero)
  );

  // ************************************************************
  // helpers
  // ************************************************************

  // start shifting one byte out of or into the buffer
  task launch_byte;
    input dir;
    begin
      state_r   <= `SMB_ST_BITS;
      bit_cnt_r <= `SMB_BIT_FIRST;
      tx_r      <= dir;
      tx_sh_r   <= buf_r;
      sda_oe_r  <= dir & ~buf_r[7];
    end
  endtask

  // enter the wait-for-software state
  task post_status;
    input hold_scl;
    begin
      state_r  <= `SMB_ST_HOLD;
      si_r     <= 1'h1;
      scl_oe_r <= hold_scl;
    end
  endtask

  // ************************************************************
  // protocol engine
  // ************************************************************
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_r    <= `SMB_ST_IDLE;
      phase_r    <= `SMB_PH_0;
      bit_cnt_r  <= `SMB_BIT_FIRST;
      buf_r      <= `SMB_BYTE_ZERO;
      rx_sh_r    <= `SMB_BYTE_ZERO;
      tx_sh_r    <= `SMB_BYTE_ZERO;
      scl_o      <= 1'h0;
      sda_o      <= 1'h0;
      scl_oe_r   <= 1'h0;
      sda_oe_r   <= 1'h0;
      master_r   <= 1'h0;
      tx_r       <= 1'h0;
      sta_r      <= 1'h0;
      sto_r      <= 1'h0;
      ack_request_flag_r    <= 1'h0;
      arbl_r     <= 1'h0;
      ack_r      <= 1'h0;
      si_r       <= 1'h0;
      busy_r     <= 1'h0;
      addr_ph_r  <= 1'h0;
      rw_r       <= 1'h0;
      rep_r      <= 1'h0;
      skip_fall_r <= 1'h0;
      tmr_load_r <= 1'h0;
      tmr_val_r  <= `SMB_TMR_ZERO;
    end
    else
    begin
      tmr_load_r <= 1'h0;
      if (data_we_i)
        buf_r <= data_i;
      if (ack_we_i)
        ack_r <= ack_i;
      if (start_det)
        busy_r <= 1'h1;
      else if (stop_det)
        busy_r <= 1'h0;
      if (!enable_i)
      begin
        state_r  <= `SMB_ST_IDLE;
        scl_oe_r <= 1'h0;
        sda_oe_r <= 1'h0;
        master_r <= 1'h0;
        si_r     <= 1'h0;
        sta_r    <= 1'h0;
        sto_r    <= 1'h0;
        ack_request_flag_r  <= 1'h0;
        arbl_r   <= 1'h0;
      end
      else
      begin
        // master clock generator with sync to other masters
        if (master_r && (state_r == `SMB_ST_BITS || state_r == `SMB_ST_ACKB))
        begin
          if (scl_oe_r)
          begin
            if (tmr_done)
              scl_oe_r <= 1'h0;
          end
          else if (scl_fall || (scl_s_r && tmr_done && !scl_rise))
          begin
            scl_oe_r   <= 1'h1;
            tmr_load_r <= 1'h1;
            tmr_val_r  <= low_val;
          end
          else if (scl_rise)
          begin
            tmr_load_r <= 1'h1;
            tmr_val_r  <= HALF_W;
          end
        end
        case (state_r)
          `SMB_ST_IDLE:
          begin
            if (start_det)
            begin
              state_r   <= `SMB_ST_BITS;
              bit_cnt_r <= `SMB_BIT_FIRST;
              tx_r      <= 1'h0;
              addr_ph_r <= 1'h1;
              skip_fall_r <= 1'h1;
              arbl_r    <= 1'h0;
              sta_r     <= 1'h0;
              sto_r     <= 1'h0;
            end
            else if (start_req_i && !busy_r)
            begin
              state_r <= `SMB_ST_MSTART;
              phase_r <= `SMB_PH_0;
              rep_r   <= 1'h0;
            end
          end
          `SMB_ST_MSTART:
          begin
            case (phase_r)
              `SMB_PH_0:
              begin
                sda_oe_r   <= 1'h0;
                tmr_load_r <= 1'h1;
                tmr_val_r  <= low_val;
                phase_r    <= `SMB_PH_1;
              end
              `SMB_PH_1:
                if (tmr_done)
                begin
                  scl_oe_r <= 1'h0;
                  phase_r  <= `SMB_PH_2;
                end
              `SMB_PH_2:
                if (scl_s_r && !sda_s_r)
                begin
                  // another master owns the wire
                  master_r <= 1'h0;
                  if (rep_r)
                  begin
                    arbl_r <= 1'h1;
                    tx_r   <= 1'h0;
                    sta_r  <= 1'h1;
                    sto_r  <= 1'h0;
                    post_status(1'h0);
                  end
                  else
                    state_r <= `SMB_ST_IDLE;
                end
                else if (scl_s_r)
                begin
                  tmr_load_r <= 1'h1;
                  tmr_val_r  <= HALF_W;
                  phase_r    <= `SMB_PH_3;
                end
              `SMB_PH_3:
                if (tmr_done)
                begin
                  sda_oe_r   <= 1'h1;
                  tmr_load_r <= 1'h1;
                  tmr_val_r  <= HALF_W;
                  phase_r    <= `SMB_PH_4;
                end
              default:
                if (tmr_done)
                begin
                  master_r <= 1'h1;
                  tx_r     <= 1'h1;
                  sta_r    <= 1'h1;
                  sto_r    <= 1'h0;
                  arbl_r   <= 1'h0;
                  post_status(1'h1);
                end
            endcase
          end
          `SMB_ST_BITS, `SMB_ST_ACKB:
          begin
            if (stop_det)
            begin
              sda_oe_r <= 1'h0;
              sto_r    <= 1'h1;
              sta_r    <= 1'h0;
              tx_r     <= 1'h0;
              arbl_r   <= master_r;
              master_r <= 1'h0;
              if (!master_r && addr_ph_r && state_r == `SMB_ST_BITS)
                state_r <= `SMB_ST_IDLE;
              else
                post_status(1'h0);
            end
            else if (start_det && !master_r)
            begin
              bit_cnt_r <= `SMB_BIT_FIRST;
              state_r   <= `SMB_ST_BITS;
              addr_ph_r <= 1'h1;
              skip_fall_r <= 1'h1;
              tx_r      <= 1'h0;
              sda_oe_r  <= 1'h0;
            end
            else if (state_r == `SMB_ST_BITS)
            begin
              if (scl_rise)
              begin
                rx_sh_r <= {rx_sh_r[6:0], sda_s_r};
                if (master_r && tx_r && !sda_oe_r && !sda_s_r)
                begin
                  master_r <= 1'h0;
                  arbl_r   <= 1'h1;
                  tx_r     <= 1'h0;
                  sta_r    <= 1'h0;
                  if (!addr_ph_r)
                    post_status(1'h0);
                end
              end
              // the fall that closes a start is not a bit
              if (scl_fall && skip_fall_r)
                skip_fall_r <= 1'h0;
              else if (scl_fall && bit_cnt_r == `SMB_BIT_LAST)
              begin
                state_r <= `SMB_ST_ACKB;
                if (addr_ph_r && !master_r)
                begin
                  buf_r <= rx_sh_r;
                  rw_r  <= rx_sh_r[0];
                  sta_r <= 1'h1;
                  if (!hardware_ack_enable_i)
                  begin
                    ack_request_flag_r <= 1'h1;
                    post_status(1'h1);
                  end
                  else if (rx_sh_r[7:1] == slave_addr_i)
                    sda_oe_r <= 1'h1;
                  else if (arbl_r)
                  begin
                    sta_r <= 1'h0;
                    post_status(1'h0);
                  end
                  else
                    state_r <= `SMB_ST_IDLE;
                end
                else if (tx_r)
                  sda_oe_r <= 1'h0;
                else
                begin
                  buf_r <= rx_sh_r;
                  if (hardware_ack_enable_i)
                    sda_oe_r <= ack_r;
                  else
                  begin
                    ack_request_flag_r <= 1'h1;
                    post_status(1'h1);
                  end
                end
              end
              else if (scl_fall)
              begin
                bit_cnt_r <= bit_cnt_r + {{(`SMB_BIT_CNT_W-1){1'h0}}, 1'h1};
                tx_sh_r   <= {tx_sh_r[6:0], 1'h0};
                sda_oe_r  <= tx_r & ~tx_sh_r[6];
              end
            end
            else
            begin
              if (scl_rise && tx_r)
                ack_r <= ~sda_s_r;
              if (scl_fall)
              begin
                sda_oe_r <= 1'h0;
                if (hardware_ack_enable_i || tx_r || master_r)
                  post_status(1'h1);
                else if (ack_r)
                begin
                  addr_ph_r <= 1'h0;
                  launch_byte(addr_ph_r ? rw_r : tx_r);
                  sta_r     <= 1'h0;
                end
                else
                  state_r <= `SMB_ST_IDLE;
              end
            end
          end
          `SMB_ST_HOLD:
          begin
            if (stop_det && !master_r && !sto_r)
            begin
              sto_r <= 1'h1;
              sta_r <= 1'h0;
              tx_r  <= 1'h0;
              post_status(1'h0);
            end
            else if (flag_clr_i)
            begin
              si_r    <= 1'h0;
              ack_request_flag_r <= 1'h0;
              if (sto_r || (!scl_oe_r && !master_r) || (start_req_i && !master_r))
              begin
                // finished, aborted or rescheduled
                state_r  <= `SMB_ST_IDLE;
                scl_oe_r <= 1'h0;
                sda_oe_r <= 1'h0;
                sto_r    <= 1'h0;
                sta_r    <= 1'h0;
                arbl_r   <= 1'h0;
                tx_r     <= 1'h0;
              end
              else if (start_req_i)
              begin
                state_r <= `SMB_ST_MSTART;
                phase_r <= `SMB_PH_0;
                rep_r   <= 1'h1;
              end
              else if (stop_req_i && master_r)
              begin
                state_r <= `SMB_ST_MSTOP;
                phase_r <= `SMB_PH_0;
              end
              else
              begin
                if (master_r)
                begin
                  tmr_load_r <= 1'h1;
                  tmr_val_r  <= low_val;
                end
                else
                  scl_oe_r <= 1'h0;
                sta_r <= 1'h0;
                if (ack_request_flag_r)
                begin
                  state_r  <= `SMB_ST_ACKB;
                  sda_oe_r <= ack_r;
                end
                else if (master_r && sta_r)
                begin
                  addr_ph_r <= 1'h1;
                  rw_r      <= buf_r[0];
                  launch_byte(1'h1);
                end
                else if (addr_ph_r)
                begin
                  addr_ph_r <= 1'h0;
                  launch_byte(master_r ? ~rw_r : rw_r);
                end
                else
                  launch_byte(tx_r);
              end
            end
          end
          default:
          begin
            case (phase_r)
              `SMB_PH_0:
              begin
                sda_oe_r   <= 1'h1;
                tmr_load_r <= 1'h1;
                tmr_val_r  <= low_val;
                phase_r    <= `SMB_PH_1;
              end
              `SMB_PH_1:
                if (tmr_done)
                begin
                  scl_oe_r <= 1'h0;
                  phase_r  <= `SMB_PH_2;
                end
              `SMB_PH_2:
                if (scl_s_r)
                begin
                  tmr_load_r <= 1'h1;
                  tmr_val_r  <= HALF_W;
                  phase_r    <= `SMB_PH_3;
                end
              `SMB_PH_3:
                if (tmr_done)
                begin
                  sda_oe_r   <= 1'h0;
                  tmr_load_r <= 1'h1;
                  tmr_val_r  <= HALF_W;
                  phase_r    <= `SMB_PH_4;
                end
              default:
                if (tmr_done)
                begin
                  master_r <= 1'h0;
                  tx_r     <= 1'h0;
                  sta_r    <= 1'h0;
                  if (sda_s_r)
                    state_r <= `SMB_ST_IDLE;
                  else
                  begin
                    sto_r  <= 1'h1;
                    arbl_r <= 1'h1;
                    post_status(1'h0);
                  end
                end
            endcase
          end
        endcase
      end
    end
  end

  // ************************************************************
  // outputs straight from flops
  // ************************************************************
  assign scl_oe_o                = scl_oe_r;
  assign sda_oe_o                = sda_oe_r;
  assign serial_byte_buffer_o    = buf_r;
  assign status_vector_o         = {master_r, tx_r, sta_r, sto_r};
  assign ack_request_flag_o      = ack_request_flag_r;
  assign arbitration_lost_flag_o = arbl_r;
  assign ack_o                   = ack_r;
  assign int_flag_o              = si_r;
  assign bus_busy_o              = busy_r;

endmodule // smbus_master_slave_interface

// ---- verification/smbus_master_slave_interface_properties.sv ----
// Purpose: port level checks of the two-wire interface
// Assumes: bound into every interface instance
// Notes:   one clock domain, reset synchronous active low
`timescale 1ns/1ps
module smbus_master_slave_interface_properties (
  input wire       clk_i,
  input wire       rstn_i,
  input wire       enable_i,
  input wire       flag_clr_i,
  input wire       scl_i,
  input wire       sda_i,
  input wire       scl_o,
  input wire       scl_oe_o,
  input wire       sda_o,
  input wire       sda_oe_o,
  input wire [3:0] status_vector_o,
  input wire       ack_request_flag_o,
  input wire       arbitration_lost_flag_o,
  input wire       int_flag_o,
  input wire       bus_busy_o
);
  // ************
  // properties
  // ************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // pins only pulled low, engine off releases all
  property p_open_drain; !scl_o && !sda_o; endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_off; !enable_i ##1 !enable_i |-> !scl_oe_o && !sda_oe_o && !int_flag_o; endproperty
  a_off: assert property (p_off) else $error("disabled engine still active");
  // flag waits for software, clock held meanwhile unless arbitration lost or status shows a stop
  property p_flag_stands; int_flag_o && enable_i && !flag_clr_i |=> int_flag_o; endproperty
  a_flag_stands: assert property (p_flag_stands) else $error("flag dropped alone");
  property p_hold; int_flag_o && !arbitration_lost_flag_o && status_vector_o != 4'h1 |-> scl_oe_o; endproperty
  a_hold: assert property (p_hold) else $error("clock not held");
  property p_ack_request_flag; ack_request_flag_o |-> int_flag_o; endproperty
  a_ack_request_flag: assert property (p_ack_request_flag) else $error("ack request without flag");
  // start on the wire marks the bus busy
  property p_start; enable_i && scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] bus_busy_o; endproperty
  a_start: assert property (p_start) else $error("start not seen");
  // minimum clock phases
  property p_scl_high; $fell(scl_oe_o) |=> !scl_oe_o [*2]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  property p_scl_low; $rose(scl_oe_o) |-> scl_oe_o [*3]; endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low too short");
endmodule // smbus_master_slave_interface_properties
bind smbus_master_slave_interface smbus_master_slave_interface_properties props (.*);

// ---- verification/smbus_far_end.sv ----
// Purpose: far side slave listener and master of the two-wire bus
// Assumes: bench resolves both lines with pull-ups
// Notes:   a high pull output holds its line low
`timescale 1ns/1ps
module smbus_far_end (
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       scl_pull_o,
  output wire       sda_pull_o,
  output reg  [7:0] rx_byte_o
);
  reg [3:0] n = 4'h0;
  reg [7:0] sh = 8'h00;
  reg       sc = 1'b0, sd = 1'b0, ak = 1'b0, hold = 1'b0, mst = 1'b0, slow = 1'b0;
  integer   k, i;
  // ************
  // listener
  // ************
  // lines are pulled low or released only
  assign scl_pull_o = sc | hold;
  assign sda_pull_o = sd | ak;
  // start on the wire restarts the bit count
  always @(negedge sda_i)
    if (scl_i)
      n = 4'h0;
  // msb first, byte closes on the ack clock
  always @(posedge scl_i)
    if (n == 4'h8)
      n = 4'h0;
    else
    begin
      sh = {sh[6:0], sda_i};
      n = n + 4'h1;
      rx_byte_o = sh;
    end
  // ack as slave, optional stretch of the low phase
  always @(negedge scl_i)
  begin
    ak = (n == 4'h8) && !mst;
    if (ak && slow)
    begin
      hold = 1'b1;
      #1000 hold = 1'b0;
    end
  end
  // ************
  // master side
  // ************
  // bounded wait while a slave stretches the clock
  task wt;
    for (k = 0; k < 400 && !scl_i; k = k + 1)
      #25;
    if (!scl_i)
    begin
      testbench.errors = testbench.errors + 1;
      testbench.report_and_stop;
    end
  endtask
  // one bit: data while low, sample while high
  task tbit(input b, output r);
    sd = !b;
    #50 sc = 1'b0;
    wt;
    #50 r = sda_i;
    #50 sc = 1'b1;
    #50;
  endtask
  task start;
    mst = 1'b1;
    sd = 1'b1;
    #100 sc = 1'b1;
  endtask
  task send(input [7:0] b, output a);
    reg r;
    for (i = 7; i >= 0; i = i - 1)
      tbit(b[i], r);
    tbit(1'b1, r);
    a = !r;
  endtask
  task stop;
    sd = 1'b1;
    #50 sc = 1'b0;
    wt;
    #100 sd = 1'b0;
    #100 mst = 1'b0;
  endtask
endmodule // smbus_far_end

// ---- verification/testbench.sv ----
// Purpose: self-checking bench of the two-wire interface
// Assumes: far end model shares both pulled-up lines
// Notes:   short half period keeps the run brief
`timescale 1ns/1ps
module testbench;
  reg        clk_i = 1'b0, rstn_i = 1'b0, enable_i = 1'b0, hardware_ack_enable_i = 1'b0;
  reg        start_req_i = 1'b0, stop_req_i = 1'b0, ack_we_i = 1'b0, ack_i = 1'b0;
  reg        data_we_i = 1'b0, flag_clr_i = 1'b0, a1, a2;
  reg  [6:0] slave_addr_i = 7'h2C;
  reg  [7:0] data_i = 8'h00, low_ext_i = 8'h02;
  wire       scl_o, scl_oe_o, sda_o, sda_oe_o, ack_request_flag_o, arbitration_lost_flag_o;
  wire       ack_o, int_flag_o, bus_busy_o, f_scl, f_sda;
  wire [7:0] serial_byte_buffer_o, f_rx;
  wire [3:0] status_vector_o;
  wire       scl_i = !(scl_oe_o | f_scl);
  wire       sda_i = !(sda_oe_o | f_sda);
  integer    errors = 0, tests_run = 0, k;
  smbus_master_slave_interface #(.HALF_CYC(4)) dut (.*);
  smbus_far_end far (.scl_i(scl_i), .sda_i(sda_i), .scl_pull_o(f_scl), .sda_pull_o(f_sda), .rx_byte_o(f_rx));
  // 40 MHz system clock
  initial
    forever #12.5 clk_i = !clk_i;
  // ************
  // checks and software access
  // ************
  task report_and_stop;
    $display("errors %0d checks %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e, input string n);
    tests_run = tests_run + 1;
    if (s !== e)
    begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // bounded wait for the flag, then its status
  task flag_status(input logic [3:0] e);
    for (k = 0; k < 4000 && int_flag_o !== 1'b1; k = k + 1)
      @(negedge clk_i);
    if (k == 4000)
    begin
      errors = errors + 1;
      report_and_stop;
    end
    else
      chk({2'h0, ack_request_flag_o, arbitration_lost_flag_o, status_vector_o}, {4'h0, e}, "status");
  endtask
  // load byte buffer, then release the held flag
  task clr(input logic [7:0] d);
    @(negedge clk_i);
    data_i = d;
    data_we_i = 1'b1;
    @(negedge clk_i);
    data_we_i = 1'b0;
    start_req_i = 1'b0;
    flag_clr_i = 1'b1;
    @(negedge clk_i);
    flag_clr_i = 1'b0;
  endtask
  // ************
  // scenarios
  // ************
  initial
  begin
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    enable_i = 1'b1;
    // master write, second byte stretched by the slave
    start_req_i = 1'b1;
    flag_status(4'hE);
    chk({7'h00, scl_i}, 8'h00, "clock held");
    clr(8'hA2);
    flag_status(4'hC);
    chk({7'h00, ack_o}, 8'h01, "addr ack");
    chk(f_rx, 8'hA2, "addr byte");
    far.slow = 1'b1;
    clr(8'h3C);
    flag_status(4'hC);
    chk(f_rx, 8'h3C, "data byte");
    far.slow = 1'b0;
    stop_req_i = 1'b1;
    clr(8'h00);
    for (k = 0; k < 400 && bus_busy_o !== 1'b0; k = k + 1)
      @(negedge clk_i);
    if (k == 400)
    begin
      errors = errors + 1;
      report_and_stop;
    end
    stop_req_i = 1'b0;
    chk({6'h00, scl_i, sda_i}, 8'h03, "idle lines");
    // slave receive with hardware address match
    hardware_ack_enable_i = 1'b1;
    ack_i = 1'b1;
    ack_we_i = 1'b1;
    @(negedge clk_i);
    ack_we_i = 1'b0;
    // let the engine settle back to idle first
    repeat (8) @(negedge clk_i);
    fork
      begin
        far.start;
        far.send(8'h58, a1);
        far.send(8'h5A, a2);
        far.stop;
      end
      begin
        flag_status(4'h2);
        clr(8'h00);
        flag_status(4'h0);
        chk(serial_byte_buffer_o, 8'h5A, "slave byte");
        clr(8'h00);
        flag_status(4'h1);
        clr(8'h00);
      end
    join
    chk({7'h00, a1}, 8'h01, "slave addr ack");
    chk({7'h00, a2}, 8'h01, "slave data ack");
    report_and_stop;
  end
endmodule // testbench
